/* hdl/sccs_pkg.sv */
// Purpose: shared constants for the switching clock sync control
// Assumes: pclk at 10 MHz, apb with 32-bit data
// Notes:   offsets are byte addresses
`default_nettype none
package sccs_pkg;
    // ------------
    // bus and register map
    // ------------
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
    // ctrl fields
    localparam int          C_SPREAD_EN     = 0;
    localparam int          C_SPREAD_RANGE  = 1;
    localparam int          C_EXT_EN        = 2;
    localparam int          C_BAND          = 3;
    localparam int          C_SOUT_EN       = 4;
    localparam int          C_FAULT_MASK    = 5;
    // status fields
    localparam int          S_FAULT_FLAG    = 0;
    localparam int          S_FAULT_LIVE    = 1;
    localparam int          S_EXT_SEL       = 2;
    localparam int          S_SPREAD_ACT    = 3;
    localparam int          S_PLL_EN        = 4;
    localparam logic [1:0]  REG_CTRL        = 2'h0;
    localparam logic [1:0]  REG_STATUS      = 2'h1;
    localparam logic [1:0]  REG_NONE        = 2'h2;
    // ------------
    // timing
    // ------------
    localparam int          PCLK_KHZ        = 10000;
    localparam int          SPREAD_MOD_KHZ  = 24;
    localparam int          MOD_CYCLES      = PCLK_KHZ / SPREAD_MOD_KHZ;
    localparam int          LIM_NARROW_PCT  = 5;
    localparam int          LIM_WIDE_PCT    = 10;
    localparam int          STEP_NARROW     = MOD_CYCLES / (4 * LIM_NARROW_PCT);
    localparam int          STEP_WIDE       = MOD_CYCLES / (4 * LIM_WIDE_PCT);
    localparam int          HF_DIVIDE       = 8;
    localparam int          BAND0_MIN_KHZ   = 2000;
    localparam int          BAND0_MAX_KHZ   = 3000;
    localparam int          BAND1_MIN_KHZ   = 333;
    localparam int          BAND1_MAX_KHZ   = 500;
    // shortest and longest accepted periods in pclk cycles
    localparam int          B0_PER_MIN      = PCLK_KHZ / BAND0_MAX_KHZ;
    localparam int          B0_PER_MAX      = (PCLK_KHZ + BAND0_MIN_KHZ - 1) / BAND0_MIN_KHZ;
    localparam int          B1_PER_MIN      = PCLK_KHZ / BAND1_MAX_KHZ;
    localparam int          B1_PER_MAX      = (PCLK_KHZ + BAND1_MIN_KHZ - 1) / BAND1_MIN_KHZ;
    localparam int          PER_W           = 6;
    // boot sequence while fuse levels settle
    typedef enum logic [1:0] {SCCS_BOOT_S1, SCCS_BOOT_S2, SCCS_BOOT_S3, SCCS_BOOT_RUN} sccs_boot_e;
endpackage : sccs_pkg
`default_nettype wire

/* hdl/sccs_meter_if.sv */
// Purpose: carrier between the control core and the period meter
// Assumes: single pclk domain
// Notes:   sync_lvl is already synchronised
`default_nettype none
interface sccs_meter_if;
    logic sync_lvl;   // synchronised external clock level
    logic band_sel;   // 0 high band, 1 low band
    logic valid;      // input frequency within band
    modport meter (input sync_lvl, input band_sel, output valid);
    modport ctrl  (output sync_lvl, output band_sel, input valid);
endinterface : sccs_meter_if
`default_nettype wire

/* hdl/sccs_period_meter.sv */
// Purpose: qualifies the external clock period against the selected band
// Assumes: input level already passed two flip-flops
// Notes:   valid after one in-band period, lost on any bad or missing one
`default_nettype none
module sccs_period_meter
    import sccs_pkg::*;
(
    input  wire logic  pclk,     // apb clock
    input  wire logic  presetn,  // async reset, active low
    sccs_meter_if.meter m        // meter side
);
    typedef struct packed {
        logic             prev;
        logic             seen;
        logic [PER_W-1:0] cnt;
        logic             valid;
    } sccs_meter_s;

    sccs_meter_s q, d;
    logic [PER_W-1:0] pmin;
    logic [PER_W-1:0] pmax;

    // ------------
    // period measurement
    // ------------
    always_comb begin
        pmin = m.band_sel ? PER_W'(B1_PER_MIN) : PER_W'(B0_PER_MIN);
        pmax = m.band_sel ? PER_W'(B1_PER_MAX) : PER_W'(B0_PER_MAX);
        d = q;
        d.prev = m.sync_lvl;
        if (m.sync_lvl && !q.prev) begin
            // rising edge closes a period
            d.valid = q.seen && (q.cnt >= pmin) && (q.cnt <= pmax);
            d.seen = 1'b1;
            d.cnt = PER_W'(1);
        end else if (q.cnt > pmax) begin
            // no edge in time: clock missing, hold counter saturated
            d.valid = 1'b0;
            d.seen = 1'b0;
        end else begin
            d.cnt = q.cnt + PER_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign m.valid = q.valid;
endmodule : sccs_period_meter
`default_nettype wire

/* hdl/sccs_clock_ctrl.sv */
// Purpose: spread spectrum, external sync selection and sync output control
// Assumes: hf_clock and ext_sync_input slow enough to be sampled by pclk
// Notes:   fuse defaults load three cycles after reset release
//
// Local design decisions: the address map and the APB interface to the registers.
`default_nettype none
// Operation
// - spread bit turns modulation on or off
// - spread enable loads fuse default
// - range bit limits deviation five or ten
// - range bit loads fuse default
// - modulate at 24 kHz on internal clock; code sweeps in 400 pclk cycles, 25 kHz
// - external sync enable forces spread off
// - fuse zero: pll off, internal only
// - fuse one: pll on, either source
// - out-of-band input frequency is invalid
// - band bit loads fuse default
// - bad clock: fall back, flag, interrupt
// - live bit follows input validity
// - return after flag cleared and valid
// - sync output carries switching frequency
// - sync output low or toggling per enable
// - sync output enable loads fuse default
// - internal switching is hf divided by eight
module sccs_clock_ctrl
(
    input  wire logic                          pclk,                        // apb clock
    input  wire logic                          presetn,                     // async reset, active low
    input  wire logic                          psel,                        // apb select
    input  wire logic                          penable,                     // apb access phase
    input  wire logic                          pwrite,                      // apb direction
    input  wire logic [sccs_pkg::ADDR_W-1:0]   paddr,                       // apb byte address
    input  wire logic [sccs_pkg::DATA_W-1:0]   pwdata,                      // apb write data
    output logic      [sccs_pkg::DATA_W-1:0]   prdata,                      // apb read data
    output logic                               pready,                      // apb ready
    output logic                               pslverr,                     // apb error, unmapped
    input  wire logic                          hf_clock,                    // internal hf clock level
    input  wire logic                          ext_sync_input,              // external sync pin
    input  wire logic                          spread_enable_default_fuse,  // fuse default
    input  wire logic                          spread_range_default_fuse,   // fuse default
    input  wire logic                          ext_sync_enable_fuse,        // sync feature fuse
    input  wire logic                          ext_sync_band_default_fuse,  // fuse default
    input  wire logic                          sync_output_default_fuse,    // fuse default
    output logic                               sync_output,                 // sync output pin
    output logic                               irq_out_n,                   // interrupt, active low
    output logic                               pll_enable,                  // pll running
    output logic                               ext_clock_selected,          // external source in use
    output logic                               spread_active,               // modulation running
    output logic signed [4:0]                  spread_offset_pct            // current deviation, %
);
    import sccs_pkg::*;

    // ------------
    // state
    // ------------
    typedef struct packed {
        logic [4:0]         fuse_s1;
        logic [4:0]         fuse_s2;
        logic               hf_s1;
        logic               hf_s2;
        logic               hf_prev;
        logic               ext_s1;
        logic               ext_s2;
        sccs_boot_e         boot;
        logic               spread_en;
        logic               spread_rng;
        logic               ext_en;
        logic               band;
        logic               sout_en;
        logic               fault_mask;
        logic               fault_flag;
        logic               fault_live;
        logic               use_ext;
        logic               pll_en;
        logic               spread_act;
        logic [1:0]         hf_cnt;
        logic               int_sw;
        logic               sout;
        logic [7:0]         step_cnt;
        logic signed [4:0]  offset;
        logic               dir_up;
        logic [DATA_W-1:0]  rdata;
        logic               ready;
        logic               slverr;
        logic               irq_n;
    } sccs_state_s;

    sccs_state_s q, d;

    sccs_meter_if mif ();

    // ------------
    // helpers
    // ------------
    // address decode, shared by the read, write and error paths
    function automatic logic [1:0] reg_index(input logic [ADDR_W-1:0] a);
        logic [1:0] r;
        r = REG_NONE;
        if (a == CTRL_OFFSET) begin
            r = REG_CTRL;
        end else if (a == STATUS_OFFSET) begin
            r = REG_STATUS;
        end
        return r;
    endfunction : reg_index

    logic              wr_ctrl;
    logic              wr_status;
    logic              ext_path;
    logic              set_fault;
    logic [7:0]        step_lim;
    logic signed [4:0] lim;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] stat_word;

    // ------------
    // period meter
    // ------------
    assign mif.sync_lvl = q.ext_s2;
    assign mif.band_sel = q.band;

    sccs_period_meter u_meter (
        .pclk    (pclk),
        .presetn (presetn),
        .m       (mif.meter)
    );

    // ------------
    // next state
    // ------------
    always_comb begin
        d = q;

        // register views
        ctrl_word = '0;
        ctrl_word[C_SPREAD_EN]    = q.spread_en;
        ctrl_word[C_SPREAD_RANGE] = q.spread_rng;
        ctrl_word[C_EXT_EN]       = q.ext_en;
        ctrl_word[C_BAND]         = q.band;
        ctrl_word[C_SOUT_EN]      = q.sout_en;
        ctrl_word[C_FAULT_MASK]   = q.fault_mask;
        stat_word = '0;
        stat_word[S_FAULT_FLAG]   = q.fault_flag;
        stat_word[S_FAULT_LIVE]   = q.fault_live;
        stat_word[S_EXT_SEL]      = q.use_ext;
        stat_word[S_SPREAD_ACT]   = q.spread_act;
        stat_word[S_PLL_EN]       = q.pll_en;

        // two-flop synchronisers; only stage two feeds logic
        d.fuse_s1 = {sync_output_default_fuse, ext_sync_band_default_fuse, ext_sync_enable_fuse,
                     spread_range_default_fuse, spread_enable_default_fuse};
        d.fuse_s2 = q.fuse_s1;
        d.hf_s1   = hf_clock;
        d.hf_s2   = q.hf_s1;
        d.hf_prev = q.hf_s2;
        d.ext_s1  = ext_sync_input;
        d.ext_s2  = q.ext_s1;

        // apb: answer in the access cycle, data prepared at setup
        wr_ctrl   = psel && penable && q.ready && pwrite && (reg_index(paddr) == REG_CTRL);
        wr_status = psel && penable && q.ready && pwrite && (reg_index(paddr) == REG_STATUS);
        d.ready   = psel && !penable;
        d.slverr  = psel && !penable && (reg_index(paddr) == REG_NONE);
        d.rdata   = '0;
        if (psel && !penable && !pwrite) begin
            unique case (reg_index(paddr))
                REG_CTRL:   d.rdata = ctrl_word;
                REG_STATUS: d.rdata = stat_word;
                default:    d.rdata = '0;
            endcase
        end
        if (wr_ctrl) begin
            d.spread_en  = pwdata[C_SPREAD_EN];
            d.spread_rng = pwdata[C_SPREAD_RANGE];
            d.ext_en     = pwdata[C_EXT_EN];
            d.band       = pwdata[C_BAND];
            d.sout_en    = pwdata[C_SOUT_EN];
            d.fault_mask = pwdata[C_FAULT_MASK];
        end

        // fuse defaults once their levels have settled
        unique case (q.boot)
            SCCS_BOOT_S1: begin
                d.boot = SCCS_BOOT_S2;
            end
            SCCS_BOOT_S2: begin
                d.boot = SCCS_BOOT_S3;
            end
            SCCS_BOOT_S3: begin
                // only now has the fuse level passed both flops
                d.boot       = SCCS_BOOT_RUN;
                d.spread_en  = q.fuse_s2[0];
                d.spread_rng = q.fuse_s2[1];
                d.pll_en     = q.fuse_s2[2];
                d.ext_en     = q.fuse_s2[2];
                d.band       = q.fuse_s2[3];
                d.sout_en    = q.fuse_s2[4];
            end
            SCCS_BOOT_RUN: begin
                d.boot = SCCS_BOOT_RUN;
            end
        endcase

        // source selection and fault handling
        ext_path     = q.pll_en && q.ext_en;
        d.fault_live = ext_path && !mif.valid;
        set_fault    = ext_path && !mif.valid;
        // a new fault beats a clear in the same cycle
        d.fault_flag = (q.fault_flag && !(wr_status && pwdata[S_FAULT_FLAG])) || set_fault;
        // back to external only with the flag gone and a good clock
        d.use_ext    = ext_path && mif.valid && !q.fault_flag;
        d.irq_n      = !(d.fault_flag && !q.fault_mask);

        // internal switching clock: hf divided by eight
        if (q.hf_s2 && !q.hf_prev) begin
            d.hf_cnt = q.hf_cnt + 2'h1;
            if (q.hf_cnt == 2'(HF_DIVIDE / 2 - 1)) begin
                d.int_sw = !q.int_sw;
            end
        end

        // sync output follows the switching clock in use
        if (!q.sout_en) begin
            d.sout = 1'b0;
        end else if (q.use_ext) begin
            d.sout = q.ext_s2;
        end else begin
            d.sout = q.int_sw;
        end

        // spread spectrum: triangle at the modulation rate
        d.spread_act = q.spread_en && !ext_path && !q.use_ext;
        lim      = q.spread_rng ? 5'(LIM_WIDE_PCT) : 5'(LIM_NARROW_PCT);
        step_lim = q.spread_rng ? 8'(STEP_WIDE) : 8'(STEP_NARROW);
        if (!q.spread_act) begin
            d.offset   = '0;
            d.dir_up   = 1'b1;
            d.step_cnt = '0;
        end else if ((q.offset > lim) || (q.offset < -lim)) begin
            // range narrowed mid-sweep: restart from the centre
            d.offset   = '0;
            d.step_cnt = '0;
        end else if (q.step_cnt >= step_lim - 8'h1) begin
            d.step_cnt = '0;
            if (q.dir_up) begin
                d.offset = q.offset + 5'sd1;
                d.dir_up = (q.offset + 5'sd1) < lim;
            end else begin
                d.offset = q.offset - 5'sd1;
                d.dir_up = (q.offset - 5'sd1) <= -lim;
            end
        end else begin
            d.step_cnt = q.step_cnt + 8'h1;
        end
    end

    // ------------
    // registers
    // ------------
    // reset values are constants; fuses are copied by the boot sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q        <= '0;
            q.boot   <= SCCS_BOOT_S1;
            q.irq_n  <= 1'b1;
            q.dir_up <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------
    // outputs, all straight from flip-flops
    // ------------
    assign prdata             = q.rdata;
    assign pready             = q.ready;
    assign pslverr            = q.slverr;
    assign sync_output        = q.sout;
    assign irq_out_n          = q.irq_n;
    assign pll_enable         = q.pll_en;
    assign ext_clock_selected = q.use_ext;
    assign spread_active      = q.spread_act;
    assign spread_offset_pct  = q.offset;
endmodule : sccs_clock_ctrl
`default_nettype wire

/* tb/sccs_monitor.sv */
// Purpose: port-level checks of the clock sync control
// Assumes: single pclk domain, zero-wait apb slave
// Notes:   bound into every instance of the top module
`default_nettype none
module sccs_monitor (
    input wire logic                        pclk,               // clock
    input wire logic                        presetn,            // reset, active low
    input wire logic                        psel,               // apb select
    input wire logic                        penable,            // apb access phase
    input wire logic [sccs_pkg::DATA_W-1:0] prdata,             // read data
    input wire logic                        pready,             // apb ready
    input wire logic                        pslverr,            // apb error
    input wire logic                        irq_out_n,          // interrupt, active low
    input wire logic                        pll_enable,         // pll running
    input wire logic                        ext_clock_selected, // external source
    input wire logic                        spread_active,      // modulation on
    input wire logic signed [4:0]           spread_offset_pct   // deviation
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------
    // bus, spread and clock selection checks
    // ------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready && psel && penable)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == '0) else $error("read data outside access");
    a_spread_ext_off: assert property (ext_clock_selected |-> !spread_active)
        else $error("spread while external");
    a_spread_dev_bound: assert property (spread_offset_pct >= -10 && spread_offset_pct <= 10)
        else $error("deviation beyond ten");
    a_spread_off_zero: assert property (!spread_active [*2] |-> spread_offset_pct == 0)
        else $error("deviation while spread off");
    a_pll_gates_ext: assert property (!pll_enable |-> !ext_clock_selected)
        else $error("external without pll");
    a_fault_no_ext: assert property (!irq_out_n [*2] |-> !ext_clock_selected)
        else $error("external kept during fault");
    // main scenarios reached
    c_ext_sel: cover property (ext_clock_selected);
    c_fault_irq: cover property ($fell(irq_out_n));
    c_wide_peak: cover property (spread_offset_pct == 10);
    c_unmapped: cover property (pslverr);
endmodule : sccs_monitor
bind sccs_clock_ctrl sccs_monitor sccs_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_out_n(irq_out_n),
    .pll_enable(pll_enable), .ext_clock_selected(ext_clock_selected), .spread_active(spread_active),
    .spread_offset_pct(spread_offset_pct));
`default_nettype wire

/* tb/sccs_ext_source.sv */
// Purpose: external sync clock source in front of the sync pin
// Assumes: period set in whole pclk cycles
// Notes:   half of zero stops the clock
`default_nettype none
module sccs_ext_source (
    input  wire logic       pclk,     // bench clock
    input  wire logic [7:0] half,     // half period in cycles
    output logic            sync_pin  // external sync pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q = 8'h00;
    initial sync_pin = 1'b0;
    // equal halves keep the duty at fifty percent; stopped source parks low
    always @(posedge pclk) begin
        if (half == 8'h00) begin
            cnt_q    <= 8'h00;
            sync_pin <= 1'b0;
        end else if (cnt_q + 8'h01 >= half) begin
            cnt_q    <= 8'h00;
            sync_pin <= ~sync_pin;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : sccs_ext_source
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench for the clock sync control
// Assumes: pclk 10 MHz, hf level toggles every two cycles
// Notes:   fuses drawn at random on each boot, sync fuse set by the caller
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sccs_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, e;
    logic [7:0]        paddr, ext_half;
    logic [1:0]        hc = 2'h0;
    logic [4:0]        fz;
    logic [31:0]       pwdata, prdata, rd, r;
    logic              pready, pslverr, hf_clock, ext_sync_input, sync_output, irq_out_n;
    logic              pll_enable, ext_clock_selected, spread_active;
    logic signed [4:0] spread_offset_pct;
    int                miscompares, checked, cyc, seed, exp_ctrl;
    sccs_clock_ctrl sccs_clock_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hf_clock(hf_clock), .ext_sync_input(ext_sync_input), .spread_enable_default_fuse(fz[0]),
        .spread_range_default_fuse(fz[1]), .ext_sync_enable_fuse(fz[2]), .ext_sync_band_default_fuse(fz[3]),
        .sync_output_default_fuse(fz[4]), .sync_output(sync_output), .irq_out_n(irq_out_n),
        .pll_enable(pll_enable), .ext_clock_selected(ext_clock_selected), .spread_active(spread_active),
        .spread_offset_pct(spread_offset_pct));
    sccs_ext_source sccs_ext_source_i (.pclk(pclk), .half(ext_half), .sync_pin(ext_sync_input));
    // ------------
    // clock, hf level and hang guard
    // ------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) hc <= hc + 2'h1;
    assign hf_clock = hc[1];
    // ceiling well above the few thousand cycles the sequence takes
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            final_report;
        end
    end
    // ------------
    // shared tasks
    // ------------
    task automatic final_report;
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string s);
        apb(1'b0, a, 32'h0);
        chk(rd & m, x, s);
    endtask : rdc
    function automatic logic sel(input int k);
        return k == 0 ? ext_clock_selected : k == 1 ? irq_out_n : spread_active;
    endfunction : sel
    task automatic wait_sig(input int k, input logic v, input int lim, input string s);
        for (int n = 0; n < lim && sel(k) !== v; n++) @(posedge pclk);
        chk(sel(k), v, s);
    endtask : wait_sig
    // counts rising edges of the sync output over a span
    task automatic edges(input int span, input int lo, input int hi, input string s);
        int n = 0;
        logic p;
        p = sync_output;
        for (int c = 0; c < span; c++) begin
            @(posedge pclk);
            if (sync_output === 1'b1 && p !== 1'b1) n++;
            p = sync_output;
        end
        chk(n >= lo && n <= hi, 1'b1, s);
    endtask : edges
    // peak deviation and spacing of successive peaks
    task automatic spread_run(input int lim);
        int mx = 0, prev = 0, t0 = 0, t1 = 0;
        for (int c = 0; c < 1000; c++) begin
            @(posedge pclk);
            if (spread_offset_pct > mx) mx = spread_offset_pct;
            if (spread_offset_pct == lim && prev != lim) begin
                t0 = t1;
                t1 = c;
            end
            prev = spread_offset_pct;
        end
        chk(mx, lim, "spread peak");
        chk(t1 - t0 > MOD_CYCLES * 9 / 10 && t1 - t0 < MOD_CYCLES * 11 / 10, 1'b1, "mod period");
    endtask : spread_run
    task automatic boot(input logic ext_fuse);
        presetn  <= 1'b0;
        r        = $random(seed);
        exp_ctrl = {r[4:3], ext_fuse, r[1:0]};
        fz       <= exp_ctrl[4:0];
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rdc(CTRL_OFFSET, 32'h1f, exp_ctrl, "fuse defaults");
        rdc(STATUS_OFFSET, 32'h10, {27'h0, ext_fuse, 4'h0}, "pll status");
    endtask : boot
    // ------------
    // main sequence
    // ------------
    initial begin
        seed     = 11437;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 8'h00;
        pwdata   = 32'h0;
        ext_half = 8'h00;
        presetn  = 1'b0;
        fz       = 5'h00;
        boot(1'b1);
        r = $random(seed);
        apb(1'b1, CTRL_OFFSET, {26'h0, r[5:0]});
        rdc(CTRL_OFFSET, 32'h3f, {26'h0, r[5:0]}, "ctrl readback");
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0, "unmapped read data");
        chk(e, 1'b1, "unmapped read error");
        // spread in both ranges, then off
        apb(1'b1, CTRL_OFFSET, 32'h21); // regulators assumed in forced pwm
        spread_run(LIM_NARROW_PCT);
        chk(spread_active, 1'b1, "spread on");
        apb(1'b1, CTRL_OFFSET, 32'h23);
        spread_run(LIM_WIDE_PCT);
        apb(1'b1, CTRL_OFFSET, 32'h20);
        wait_sig(2, 1'b0, 10, "spread off");
        // external clock in band 0, spread bit set but forced off
        ext_half <= 8'd2;
        repeat (20) @(posedge pclk);
        apb(1'b1, CTRL_OFFSET, 32'h15);
        apb(1'b1, STATUS_OFFSET, 32'h1);
        wait_sig(0, 1'b1, 60, "ext selected");
        chk(spread_active, 1'b0, "spread forced off");
        edges(40, 9, 11, "sync out follows ext");
        // loss, recovery, clear
        ext_half <= 8'd0;
        wait_sig(1, 1'b0, 40, "fault irq");
        chk(ext_clock_selected, 1'b0, "fallback");
        rdc(STATUS_OFFSET, 32'h7, 32'h3, "flag and live");
        ext_half <= 8'd2;
        repeat (30) @(posedge pclk);
        rdc(STATUS_OFFSET, 32'h7, 32'h1, "sticky flag, live clear");
        apb(1'b1, STATUS_OFFSET, 32'h1);
        wait_sig(0, 1'b1, 10, "return to ext");
        chk(irq_out_n, 1'b1, "irq released");
        ext_half <= 8'd4;
        wait_sig(1, 1'b0, 40, "too slow for band 0");
        apb(1'b1, CTRL_OFFSET, 32'h1c);
        ext_half <= 8'd12;
        repeat (80) @(posedge pclk);
        apb(1'b1, STATUS_OFFSET, 32'h1);
        wait_sig(0, 1'b1, 10, "band 1 valid");
        apb(1'b1, CTRL_OFFSET, 32'h3c);
        ext_half <= 8'd0;
        repeat (80) @(posedge pclk);
        chk({irq_out_n, ext_clock_selected}, 2'b10, "masked fault");
        rdc(STATUS_OFFSET, 32'h1, 32'h1, "flag under mask");
        // sync output disabled, then internal hf divided
        apb(1'b1, CTRL_OFFSET, 32'h20);
        // the level launched at the write edge still used the old enable
        @(posedge pclk);
        edges(100, 0, 0, "sync out held low");
        chk(sync_output, 1'b0, "sync out level");
        apb(1'b1, CTRL_OFFSET, 32'h30);
        edges(640, 640 / (4 * HF_DIVIDE) - 1, 640 / (4 * HF_DIVIDE) + 1, "hf over eight");
        // sync fuse off: pll off, internal only
        ext_half <= 8'd2;
        boot(1'b0);
        apb(1'b1, CTRL_OFFSET, 32'h04);
        repeat (60) @(posedge pclk);
        chk({pll_enable, ext_clock_selected}, 2'b00, "fuse off internal");
        final_report;
    end
endmodule : tb
`default_nettype wire
